// ===== verilog/mcxs_pkg.sv
// constants and types shared by the machine cycle and external data move sequencer
package mcxs_pkg;

   // ==========================================================
   // machine cycle shape
   localparam int unsigned CLOCKS_PER_CYCLE = 4;
   localparam logic [3:0] MIN_INSTR_CYCLES = 4'h1;
   localparam logic [3:0] MAX_INSTR_CYCLES = 4'h5;
   localparam logic [3:0] MOVE_BASE_CYCLES = 4'h2;

   // ==========================================================
   // special function register map
   localparam logic [7:0] SFR_PTR_SELECT_ADDR = 8'h86;
   localparam logic [7:0] SFR_CLOCK_CONTROL_ADDR = 8'h8e;
   localparam int unsigned PTR_SELECT_BIT = 0;
   localparam int unsigned STRETCH_LSB = 0;
   localparam int unsigned STRETCH_MSB = 2;
   localparam logic [2:0] STRETCH_RESET = 3'h1;
   localparam logic PTR_SELECT_RESET = 1'b0;
   localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;

   // ==========================================================
   // strobe placement inside the access cycles, in clocks
   localparam logic [5:0] STROBE_FAST_FIRST = 6'h01;
   localparam logic [5:0] STROBE_FAST_LAST = 6'h02;
   localparam logic [5:0] STROBE_SLOW_FIRST = 6'h02;
   localparam logic [5:0] STROBE_SLOW_OFFSET = 6'h01;

   // states of one machine cycle
   typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} mcxs_phase_e;

endpackage

// ===== verilog/mcxs_sequencer.sv
// machine cycle sequencer with stretchable external data move and dual data pointers
//
// Summary of operation
// [RULE_01] each machine cycle lasts exactly four input clock periods
// [RULE_02] states phase one, two, three, four always follow in that order
// [RULE_03] both clock edges used internally; here each state is one full period
// [RULE_04] one opcode byte is fetched in every machine cycle; here none in the move's access cycles
// [RULE_05] most instructions take as many machine cycles as they have bytes
// [RULE_06] half of all opcodes finish in one machine cycle of four clocks
// [RULE_07] other instructions take one to five machine cycles
// [RULE_08] software may lengthen the external data move to two through nine cycles
// [RULE_09] lengthening the move widens the read or write strobe in proportion
// [RULE_10] the move reaches off-chip data space; results match the classic core
// [RULE_11] index form takes low address byte from the selected index register
// [RULE_12] index form takes high address byte from the port 2 output latch
// [RULE_13] pointer form drives the full 16-bit selected data pointer
// [RULE_14] pointer select flag is bit zero of the register at 86h
// [RULE_15] other seven bits of that register do nothing and read zero
// [RULE_16] flag zero selects data pointer zero, flag one selects data pointer one
// [RULE_17] incrementing or decrementing the select register toggles the active pointer
// [RULE_18] stretch field bits two to zero give a move of n plus two cycles
// [RULE_19] stretch field resets to one, a three cycle move
// [RULE_20] strobe is two clocks at stretch zero, else four clocks times stretch
// [RULE_21] pointer operations use the pointer selected when the instruction executes
`timescale 1ns/1ps
module mcxs_sequencer
   import mcxs_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RESET_N,
   // instruction descriptor, taken at phase four of the last cycle
   input wire logic [3:0] DEC_CYCLES,
   input wire logic DEC_XMOVE,
   input wire logic DEC_PTR_FORM,
   input wire logic DEC_WRITE,
   input wire logic [7:0] DEC_WDATA,
   input wire logic [7:0] INDEX_REG,
   input wire logic [7:0] PORT2_LATCH,
   // special function register port
   input wire logic SFR_WE,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   // data pointer operations from the core
   input wire logic DP_LOAD,
   input wire logic DP_INC,
   input wire logic [15:0] DP_WDATA,
   output logic [15:0] DP_VALUE,
   // cycle timing toward the core
   output logic [1:0] MC_PHASE,
   output logic FETCH_STB,
   output logic DEC_TAKE,
   // external data space
   output logic [15:0] XADDR,
   output logic XRD_N,
   output logic XWR_N,
   output logic [7:0] XDATA_OUT,
   output logic XDATA_OE,
   input wire logic [7:0] XDATA_IN,
   output logic [7:0] XMOVE_RDATA,
   output logic XMOVE_RVALID
);

   // ==========================================================
   // state
   typedef struct packed {
      mcxs_phase_e phase;
      logic [3:0] rem;
      logic mv;
      logic mv_acc;
      logic [5:0] kcnt;
      logic mv_wr;
      logic [2:0] mv_n;
      logic [15:0] mv_addr;
      logic [7:0] mv_wdata;
      logic [2:0] stretch;
      logic psel;
      logic [15:0] dp0;
      logic [15:0] dp1;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic fetch;
      logic take;
      logic xrd_n;
      logic xwr_n;
      logic [15:0] xaddr;
      logic xoe;
      logic [7:0] xdout;
      logic [7:0] rdata;
      logic rvalid;
      logic rd_close;
      logic [7:0] sfr_rdata;
      logic [15:0] dp_out;
   } mcxs_state_s;

   mcxs_state_s q;
   mcxs_state_s d;

   // ==========================================================
   // helpers
   function automatic logic [3:0] move_cycles(input logic [2:0] n);
      move_cycles = {1'b0, n} + MOVE_BASE_CYCLES; // [RULE_18]
   endfunction

   // out-of-range cycle counts from the decoder are pulled into 1..5
   function automatic logic [3:0] clamp_cycles(input logic [3:0] c);
      clamp_cycles = (c < MIN_INSTR_CYCLES) ? MIN_INSTR_CYCLES :
                     (c > MAX_INSTR_CYCLES) ? MAX_INSTR_CYCLES : c;
   endfunction

   // strobe window in clocks counted from the first access cycle
   function automatic logic strobe_active(input logic [5:0] k, input logic [2:0] n);
      strobe_active = (n == 3'h0) ?
         ((k >= STROBE_FAST_FIRST) && (k <= STROBE_FAST_LAST)) :
         ((k >= STROBE_SLOW_FIRST) && (k <= ({1'b0, n, 2'b00} + STROBE_SLOW_OFFSET)));
   endfunction

   function automatic logic [15:0] sel_ptr(input mcxs_state_s s);
      sel_ptr = s.psel ? s.dp1 : s.dp0; // [RULE_16]
   endfunction

   logic last_cycle;
   logic strobe_on;

   // ==========================================================
   // next-state logic
   always_comb
   begin
      d = q;
      d.rvalid = 1'b0;
      last_cycle = (q.phase == PH_FOUR) && (q.rem == 4'h1);
      // pin data passes two flops before anything reads it
      d.sync1 = XDATA_IN;
      d.sync2 = q.sync1;

      // fixed four-state rotation, one state per clock
      unique case (q.phase) // [RULE_01] [RULE_02] [RULE_03]
         PH_ONE: d.phase = PH_TWO;
         PH_TWO: d.phase = PH_THREE;
         PH_THREE: d.phase = PH_FOUR;
         PH_FOUR: d.phase = PH_ONE;
      endcase

      // access clock counter runs only while the move holds the core
      d.kcnt = q.mv_acc ? q.kcnt + 6'h01 : q.kcnt;

      // cycle accounting at the end of each machine cycle
      if (q.phase == PH_FOUR)
      begin
         if (last_cycle)
         begin
            d.mv = DEC_XMOVE;
            d.mv_acc = 1'b0;
            d.kcnt = 6'h00;
            d.mv_wr = DEC_WRITE;
            d.mv_n = q.stretch;
            d.mv_wdata = DEC_WDATA;
            // cycle count equals the count the decoder reports pulled into 1..5, or stretch plus two
            d.rem = DEC_XMOVE ? move_cycles(q.stretch) // [RULE_08] [RULE_18]
                              : clamp_cycles(DEC_CYCLES); // [RULE_05] [RULE_06] [RULE_07]
            d.mv_addr = DEC_PTR_FORM ? sel_ptr(q) // [RULE_13] [RULE_21]
                                     : {PORT2_LATCH, INDEX_REG}; // [RULE_11] [RULE_12]
         end
         else
         begin
            d.rem = q.rem - 4'h1;
            // after the opcode cycle the move holds the core in access cycles
            d.mv_acc = q.mv_acc || q.mv;
         end
      end

      // strobe widens with the stretch captured at move start
      strobe_on = d.mv_acc && strobe_active(d.kcnt, d.mv_n); // [RULE_09] [RULE_20]
      d.xrd_n = !(strobe_on && !d.mv_wr);
      d.xwr_n = !(strobe_on && d.mv_wr);
      d.xoe = d.mv_acc && d.mv_wr; // [RULE_10]
      d.xdout = d.mv_wdata;
      d.xaddr = d.mv_acc ? d.mv_addr : q.xaddr;

      // read data is taken one clock after the strobe closes: the pin path lags two
      // clocks, so only then does the second flop hold a sample from inside the strobe
      d.rd_close = !q.xrd_n && d.xrd_n;
      if (q.rd_close)
      begin
         d.rdata = q.sync2;
         d.rvalid = 1'b1;
      end

      // opcode fetch once per cycle, none while the move holds the core
      d.fetch = (d.phase == PH_ONE) && !d.mv_acc; // [RULE_04]
      d.take = (d.phase == PH_FOUR) && (d.rem == 4'h1);

      // register writes; stretch changes apply to the next move only
      if (SFR_WE && (SFR_ADDR == SFR_PTR_SELECT_ADDR))
      begin
         // an inc or dec of the register flips bit zero, toggling pointers
         d.psel = SFR_WDATA[PTR_SELECT_BIT]; // [RULE_14] [RULE_17]
      end
      if (SFR_WE && (SFR_ADDR == SFR_CLOCK_CONTROL_ADDR))
      begin
         d.stretch = SFR_WDATA[STRETCH_MSB:STRETCH_LSB]; // [RULE_18]
      end

      // pointer operations hit the pointer selected now; a load beats an increment
      if (DP_LOAD || DP_INC)
      begin
         if (q.psel) // [RULE_16] [RULE_21]
         begin
            d.dp1 = DP_LOAD ? DP_WDATA : q.dp1 + 16'h0001;
         end
         else
         begin
            d.dp0 = DP_LOAD ? DP_WDATA : q.dp0 + 16'h0001;
         end
      end
      d.dp_out = d.psel ? d.dp1 : d.dp0;

      // read mux; unused bits and unmapped addresses read zero
      d.sfr_rdata = (SFR_ADDR == SFR_PTR_SELECT_ADDR) ? {7'h00, d.psel} : // [RULE_15]
                    (SFR_ADDR == SFR_CLOCK_CONTROL_ADDR) ? {5'h00, d.stretch} : 8'h00;
   end

   // ==========================================================
   // state register; first phase four after reset takes the first descriptor
   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         q <= '0;
         q.phase <= PH_FOUR;
         q.rem <= MIN_INSTR_CYCLES;
         q.stretch <= STRETCH_RESET; // [RULE_19]
         q.psel <= PTR_SELECT_RESET;
         q.dp0 <= DATA_POINTER_RESET;
         q.dp1 <= DATA_POINTER_RESET;
         q.xrd_n <= 1'b1;
         q.xwr_n <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // outputs come straight from the state flops
   assign MC_PHASE = q.phase;
   assign FETCH_STB = q.fetch;
   assign DEC_TAKE = q.take;
   assign XADDR = q.xaddr;
   assign XRD_N = q.xrd_n;
   assign XWR_N = q.xwr_n;
   assign XDATA_OUT = q.xdout;
   assign XDATA_OE = q.xoe;
   assign XMOVE_RDATA = q.rdata;
   assign XMOVE_RVALID = q.rvalid;
   assign SFR_RDATA = q.sfr_rdata;
   assign DP_VALUE = q.dp_out;

   // ==========================================================
   // checks
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESET_N);

   // helper: width of the current strobe in clocks
   logic strobe_n;
   logic [5:0] strobe_len;
   assign strobe_n = XRD_N & XWR_N;
   always_ff @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         strobe_len <= 6'h00;
      end
      else
      begin
         strobe_len <= strobe_n ? 6'h00 : strobe_len + 6'h01;
      end
   end

   property p_phase_order;
      (q.phase == PH_ONE) |=> (q.phase == PH_TWO) ##1 (q.phase == PH_THREE)
         ##1 (q.phase == PH_FOUR) ##1 (q.phase == PH_ONE);
   endproperty
   a_phase_order: assert property (p_phase_order) // [RULE_02]
      else $error("machine cycle states out of order");

   property p_cycle_len;
      (MC_PHASE == 2'h0) |-> ##4 (MC_PHASE == 2'h0) ##1 (MC_PHASE != 2'h0);
   endproperty
   a_cycle_len: assert property (p_cycle_len) // [RULE_01]
      else $error("machine cycle is not four clocks");

   property p_fetch_once;
      FETCH_STB |=> !FETCH_STB [*3];
   endproperty
   a_fetch_once: assert property (p_fetch_once) // [RULE_04]
      else $error("more than one fetch in a machine cycle");

   property p_strobe_fast;
      ($fell(strobe_n) && (q.mv_n == 3'h0)) |-> !strobe_n ##1 !strobe_n ##1 strobe_n;
   endproperty
   a_strobe_fast: assert property (p_strobe_fast) // [RULE_20]
      else $error("stretch zero strobe not two clocks");

   property p_strobe_slow;
      ($rose(strobe_n) && (q.mv_n != 3'h0)) |-> (strobe_len == {1'b0, q.mv_n, 2'b00});
   endproperty
   a_strobe_slow: assert property (p_strobe_slow) // [RULE_09]
      else $error("stretched strobe width wrong");

   property p_move_len;
      (last_cycle && DEC_XMOVE) |=> (q.rem == ({1'b0, $past(q.stretch)} + 4'h2));
   endproperty
   a_move_len: assert property (p_move_len) // [RULE_18]
      else $error("move cycle count not stretch plus two");

   property p_addr_index;
      (last_cycle && DEC_XMOVE && !DEC_PTR_FORM)
         |=> (q.mv_addr == {$past(PORT2_LATCH), $past(INDEX_REG)});
   endproperty
   a_addr_index: assert property (p_addr_index) // [RULE_11] [RULE_12]
      else $error("index form address wrong");

   property p_addr_ptr;
      (last_cycle && DEC_XMOVE && DEC_PTR_FORM)
         |=> (q.mv_addr == ($past(q.psel) ? $past(q.dp1) : $past(q.dp0)));
   endproperty
   a_addr_ptr: assert property (p_addr_ptr) // [RULE_13]
      else $error("pointer form address wrong");

   property p_sel_zero_bits;
      ($past(SFR_ADDR) == SFR_PTR_SELECT_ADDR) |-> (SFR_RDATA[7:1] == 7'h00);
   endproperty
   a_sel_zero_bits: assert property (p_sel_zero_bits) // [RULE_15]
      else $error("unused select bits not zero");

   property p_dp_route;
      (DP_LOAD && !q.psel) |=> (q.dp0 == $past(DP_WDATA)) && $stable(q.dp1);
   endproperty
   a_dp_route: assert property (p_dp_route) // [RULE_16]
      else $error("load reached the wrong pointer");

   property p_plain_range;
      (last_cycle && !DEC_XMOVE) |=> (q.rem >= 4'h1) && (q.rem <= 4'h5);
   endproperty
   a_plain_range: assert property (p_plain_range) // [RULE_07]
      else $error("instruction length out of range");

   c_read_fast: cover property ($rose(XMOVE_RVALID) && (q.mv_n == 3'h0));
   c_write_long: cover property ($rose(XWR_N) && (q.mv_n == 3'h7));
   c_single_cycle: cover property (last_cycle && (DEC_CYCLES == 4'h1) && !DEC_XMOVE);

endmodule

// ===== verif/mcxs_xmem_model.sv
// external data memory model answering the sequencer's read and write strobes
`timescale 1ns/1ps
module mcxs_xmem_model
   import mcxs_pkg::*;
#(
   parameter int unsigned READ_LAG = 0
)
(
   input wire logic REF_CLK,
   input wire logic [15:0] XADDR,
   input wire logic XRD_N,
   input wire logic XWR_N,
   input wire logic [7:0] XDATA_OUT,
   input wire logic XDATA_OE,
   output logic [7:0] XDATA_IN
);
   // ==========================================================
   // storage, only the low address byte decodes to keep it small
   logic [7:0] mem [0:255];
   logic [7:0] last_q = 8'h00;
   int unsigned low_cnt = 0;

   // write while the strobe is low; the last low clock leaves the final byte
   always @(posedge REF_CLK)
   begin
      if (!XWR_N && XDATA_OE)
         mem[XADDR[7:0]] <= XDATA_OUT;
      if (!XRD_N)
         last_q <= mem[XADDR[7:0]];
      low_cnt <= XRD_N ? 0 : low_cnt + 1;
   end

   // a released bus shows the inverse of the last byte, never a stale copy
   always_comb
   begin
      if (!XRD_N && low_cnt >= READ_LAG)
         XDATA_IN = mem[XADDR[7:0]];
      else
         XDATA_IN = ~last_q;
   end
endmodule

// ===== verif/machine_cycle_extmem_sequencer_tb_top.sv
// self-checking testbench for the machine cycle and external data move sequencer
`timescale 1ns/1ps
module machine_cycle_extmem_sequencer_tb_top
   import mcxs_pkg::*;
;
   logic REF_CLK = 1'b0;
   logic RESET_N = 1'b0;
   logic [3:0] DEC_CYCLES = 4'h1;
   logic DEC_XMOVE = 1'b0, DEC_PTR_FORM = 1'b0, DEC_WRITE = 1'b0;
   logic [7:0] DEC_WDATA = 8'h00, INDEX_REG = 8'h00, PORT2_LATCH = 8'h00;
   logic SFR_WE = 1'b0;
   logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA;
   logic DP_LOAD = 1'b0, DP_INC = 1'b0;
   logic [15:0] DP_WDATA = 16'h0000, DP_VALUE, XADDR;
   logic [1:0] MC_PHASE;
   logic FETCH_STB, DEC_TAKE, XRD_N, XWR_N, XDATA_OE, XMOVE_RVALID;
   logic [7:0] XDATA_OUT, XDATA_IN, XMOVE_RDATA;
   int fail_count = 0;
   int n_compared = 0;

   // ==========================================================
   // clock, design and far-side memory
   always #5 REF_CLK = ~REF_CLK;

   mcxs_sequencer i_dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .DEC_CYCLES(DEC_CYCLES),
      .DEC_XMOVE(DEC_XMOVE), .DEC_PTR_FORM(DEC_PTR_FORM), .DEC_WRITE(DEC_WRITE),
      .DEC_WDATA(DEC_WDATA), .INDEX_REG(INDEX_REG), .PORT2_LATCH(PORT2_LATCH),
      .SFR_WE(SFR_WE), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
      .DP_LOAD(DP_LOAD), .DP_INC(DP_INC), .DP_WDATA(DP_WDATA), .DP_VALUE(DP_VALUE),
      .MC_PHASE(MC_PHASE), .FETCH_STB(FETCH_STB), .DEC_TAKE(DEC_TAKE), .XADDR(XADDR),
      .XRD_N(XRD_N), .XWR_N(XWR_N), .XDATA_OUT(XDATA_OUT), .XDATA_OE(XDATA_OE),
      .XDATA_IN(XDATA_IN), .XMOVE_RDATA(XMOVE_RDATA), .XMOVE_RVALID(XMOVE_RVALID));

   mcxs_xmem_model #(.READ_LAG(0)) i_mem (.REF_CLK(REF_CLK), .XADDR(XADDR),
      .XRD_N(XRD_N), .XWR_N(XWR_N), .XDATA_OUT(XDATA_OUT), .XDATA_OE(XDATA_OE),
      .XDATA_IN(XDATA_IN));

   // ==========================================================
   // comparison and verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // register and pointer port tasks, inputs change on the falling edge
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge REF_CLK);
      SFR_WE = 1'b1;
      SFR_ADDR = a;
      SFR_WDATA = d;
      @(negedge REF_CLK);
      SFR_WE = 1'b0;
   endtask

   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge REF_CLK);
      SFR_ADDR = a;
      @(negedge REF_CLK);
      check({8'h00, SFR_RDATA}, {8'h00, exp});
   endtask

   task automatic dp_op(input logic ld, input logic inc, input logic [15:0] d);
      @(negedge REF_CLK);
      DP_LOAD = ld;
      DP_INC = inc;
      DP_WDATA = d;
      @(negedge REF_CLK);
      DP_LOAD = 1'b0;
      DP_INC = 1'b0;
   endtask

   // ==========================================================
   // one instruction: hand over the descriptor, then watch it to the next take
   task automatic run_instr(input logic [3:0] cyc, input logic xm, input logic pf,
      input logic wr, input logic [7:0] wd, input logic [15:0] addr, input int n);
      int clk_n;
      int fetches;
      int stb;
      int guard;
      int ecyc;
      logic [7:0] rd;
      // the design pulls a zero count up to one and counts above five down to five
      ecyc = (cyc == 4'h0) ? 1 : (cyc > 4'h5) ? 5 : int'(cyc);
      clk_n = 0;
      fetches = 0;
      stb = 0;
      guard = 0;
      rd = 8'h00;
      while (DEC_TAKE !== 1'b1 && guard < 100)
      begin
         @(negedge REF_CLK);
         guard++;
      end
      DEC_CYCLES = cyc;
      DEC_XMOVE = xm;
      DEC_PTR_FORM = pf;
      DEC_WRITE = wr;
      DEC_WDATA = wd;
      INDEX_REG = pf ? ~addr[7:0] : addr[7:0];
      PORT2_LATCH = pf ? ~addr[15:8] : addr[15:8];
      do
      begin
         @(negedge REF_CLK);
         DEC_XMOVE = 1'b0;
         DEC_CYCLES = 4'h1;
         check({14'h0, MC_PHASE}, 16'(clk_n % 4));
         if (FETCH_STB === 1'b1)
            fetches++;
         if (XRD_N === 1'b0 || XWR_N === 1'b0)
         begin
            stb++;
            check(XADDR, addr);
            check({15'h0, XDATA_OE}, {15'h0, wr});
         end
         if (XMOVE_RVALID === 1'b1)
            rd = XMOVE_RDATA;
         clk_n++;
      end
      while (DEC_TAKE !== 1'b1 && clk_n < 60);
      // at stretch zero the read result lands in the first clock of the next instruction
      if (xm && !wr && n == 0)
      begin
         @(negedge REF_CLK);
         if (XMOVE_RVALID === 1'b1)
            rd = XMOVE_RDATA;
      end
      check(16'(clk_n), xm ? 16'(4 * (n + 2)) : 16'(4 * ecyc));
      check(16'(fetches), xm ? 16'h0001 : 16'(ecyc));
      check(16'(stb), !xm ? 16'h0 : (n == 0) ? 16'h2 : 16'(4 * n));
      if (xm && !wr)
         check({8'h00, rd}, {8'h00, wd});
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (4) @(negedge REF_CLK);
      RESET_N = 1'b1;
      sfr_rd(SFR_PTR_SELECT_ADDR, 8'h00);
      sfr_rd(SFR_CLOCK_CONTROL_ADDR, 8'h01);
      for (int c = 0; c <= 6; c++)
         run_instr(4'(c), 1'b0, 1'b0, 1'b0, 8'h00, 16'h0000, 0);
      run_instr(4'h1, 1'b1, 1'b0, 1'b1, 8'h5a, 16'h3377, 1);
      dp_op(1'b1, 1'b0, 16'h1234);
      check(DP_VALUE, 16'h1234);
      sfr_wr(SFR_PTR_SELECT_ADDR, 8'hff);
      check(DP_VALUE, 16'h0000);
      sfr_rd(SFR_PTR_SELECT_ADDR, 8'h01);
      dp_op(1'b1, 1'b1, 16'h5678);
      check(DP_VALUE, 16'h5678);
      dp_op(1'b0, 1'b1, 16'h0000);
      check(DP_VALUE, 16'h5679);
      sfr_wr(SFR_PTR_SELECT_ADDR, 8'h02);
      check(DP_VALUE, 16'h1234);
      sfr_wr(SFR_PTR_SELECT_ADDR, 8'h03);
      check(DP_VALUE, 16'h5679);
      sfr_wr(8'h90, 8'hff);
      sfr_rd(8'h90, 8'h00);
      // every stretch code: index-form write, then pointer-form read back
      for (int n = 0; n < 8; n++)
      begin
         sfr_wr(SFR_CLOCK_CONTROL_ADDR, {5'h1f, 3'(n)});
         sfr_rd(SFR_CLOCK_CONTROL_ADDR, {5'h00, 3'(n)});
         run_instr(4'h1, 1'b1, 1'b0, 1'b1, 8'hc0 + 8'(n), {8'h40, 8'(n)}, n);
         dp_op(1'b1, 1'b0, {8'h40, 8'(n)});
         run_instr(4'h1, 1'b1, 1'b1, 1'b0, 8'hc0 + 8'(n), {8'h40, 8'(n)}, n);
      end
      print_verdict();
   end

   // watchdog: the whole run needs under a thousand clocks
   initial
   begin
      #200000;
      fail_count++;
      print_verdict();
   end
endmodule
